/* sysctl_consts.vh */
// Purpose: constants for the reset and system control block
// Assumes: 100 MHz clk
// Notes:   times are in ns, counts derived from the clock period
`ifndef SYSCTL_CONSTS_VH
`define SYSCTL_CONSTS_VH
`define CLK_PERIOD_NS      32'd10
`define WAKE_FIXED_CYCLES  32'd64
`define WAKE_IRC_CYCLES    32'd4
`define WAKE_XTAL_CYCLES   32'd4096
`define FLASH_START_NS     32'd100000
`define FLASH_START_CYCLES (`FLASH_START_NS / `CLK_PERIOD_NS)
`define MAP_BOOT           2'h0
`define MAP_SRAM           2'h1
`define MAP_EXT            2'h2
`define RESET_VECTOR_ADDR  32'h0000_0000
`define N_EDGE_IRQ         50
`define N_LEVEL_IRQ        4
`endif

/* reset_brownout_system_control.v */
// Purpose: reset sequencing, brownout monitor, vector mapping, wake control
// Assumes: comparator and pin inputs already synchronous to clk
// Notes:   wake delays counted on clk; long counts are parameters
`timescale 1ns/1ps
`include "sysctl_consts.vh"
module reset_brownout_system_control #(
    parameter N_EDGE       = `N_EDGE_IRQ,
    parameter N_LEVEL      = `N_LEVEL_IRQ,
    parameter FIXED_CYC    = `WAKE_FIXED_CYCLES,
    parameter XTAL_CYC     = `WAKE_XTAL_CYCLES,
    parameter FLASH_CYC    = `FLASH_START_CYCLES
) (
    input  wire                 clk,
    input  wire                 srst,
    input  wire                 reset_pin_n,
    input  wire                 watchdog_reset,
    input  wire                 power_on_reset,
    input  wire                 brownout_warn,
    input  wire                 brownout_trip,
    input  wire                 osc_running,
    input  wire                 flash_init_done,
    input  wire [1:0]           map_sel,
    input  wire                 clk_src_is_irc,
    input  wire                 sleep_req,
    input  wire                 powerdown_req,
    input  wire [N_EDGE-1:0]    edge_irq_in,
    input  wire [N_LEVEL-1:0]   level_irq_in,
    input  wire [N_EDGE-1:0]    edge_irq_en,
    input  wire [N_LEVEL-1:0]   level_irq_en,
    input  wire [N_EDGE-1:0]    edge_wake_en,
    input  wire [N_LEVEL-1:0]   level_wake_en,
    input  wire                 edge_irq_clr,
    output wire                 chip_reset,
    output reg                  core_reset,
    output reg  [31:0]          fetch_addr,
    output reg  [1:0]           vector_map,
    output reg                  brownout_irq,
    output reg                  brownout_status,
    output reg  [N_EDGE-1:0]    edge_irq_flag,
    output reg  [N_LEVEL-1:0]   level_irq_flag,
    output reg                  core_run,
    output reg                  flash_ready
);
    localparam ST_RESET = 2'h0;
    localparam ST_RUN   = 2'h1;
    localparam ST_SLEEP = 2'h2;
    localparam ST_WAKE  = 2'h3;

    // true when a counter about to step reaches its limit
    function count_done;
        input [31:0] cnt;
        input [31:0] limit;
        begin
            count_done = ((cnt + 32'd1) >= limit);
        end
    endfunction

    // the spare map code falls back to the boot block
    function [1:0] map_decode;
        input [1:0] sel;
        begin
            if (sel > `MAP_EXT) begin
                map_decode = `MAP_BOOT;
            end else begin
                map_decode = sel;
            end
        end
    endfunction

    reg [1:0]         state_q;
    reg [1:0]         state_d;
    reg [31:0]        wake_cnt_q;
    reg [31:0]        wake_cnt_d;
    reg [31:0]        flash_cnt_q;
    reg [31:0]        flash_cnt_d;
    reg               pd_q;
    reg               pd_d;
    reg               irc_q;
    reg               irc_d;
    reg               core_reset_d;
    reg               core_run_d;
    reg               flash_ready_d;
    reg [1:0]         vector_map_d;
    reg               rel_meta_q;
    reg               rel_sync_q;
    reg [N_EDGE-1:0]  edge_prev_q;
    wire              src_reset;
    wire              wake_evt;
    wire              wake_done;
    wire              flash_done;
    wire              fixed_done;
    wire [31:0]       wake_limit;
    wire [N_EDGE-1:0] edge_rise;
    wire [N_EDGE-1:0] edge_keep;
    wire [N_EDGE-1:0] edge_set;

    // brownout trip holds reset; power-on covers the lowest supply
    assign src_reset  = ~reset_pin_n | watchdog_reset | power_on_reset | brownout_trip;
    // assertion is immediate, no clock needed on the way in
    assign chip_reset = src_reset | srst;
    assign edge_rise  = edge_irq_in & ~edge_prev_q;
    assign edge_keep  = edge_irq_flag & {N_EDGE{~edge_irq_clr}};
    assign edge_set   = edge_rise & edge_irq_en;
    assign wake_evt   = |(edge_rise & edge_wake_en) | |(level_irq_in & level_wake_en);
    assign wake_limit = irc_q ? `WAKE_IRC_CYCLES : XTAL_CYC;
    assign wake_done  = count_done(wake_cnt_q, wake_limit);
    assign flash_done = count_done(flash_cnt_q, FLASH_CYC);
    assign fixed_done = (wake_cnt_q >= FIXED_CYC);

    // release passes two flops so core reset never drops mid-edge
    always @(posedge clk) begin
        if (chip_reset) begin
            rel_meta_q <= 1'b0;
        end else begin
            rel_meta_q <= 1'b1;
        end
    end

    always @(posedge clk) begin
        if (chip_reset) begin
            rel_sync_q <= 1'b0;
        end else begin
            rel_sync_q <= rel_meta_q;
        end
    end

    // sequencing: reset, run, sleep or power-down, wake
    always @* begin
        state_d       = state_q;
        wake_cnt_d    = wake_cnt_q;
        flash_cnt_d   = flash_cnt_q;
        pd_d          = pd_q;
        irc_d         = irc_q;
        core_reset_d  = core_reset;
        core_run_d    = core_run;
        flash_ready_d = flash_ready;
        vector_map_d  = vector_map;
        case (state_q)
            ST_RESET: begin
                core_reset_d = 1'b1;
                // count only clocks the oscillator really delivers
                if (osc_running && !fixed_done) begin
                    wake_cnt_d = wake_cnt_q + 32'd1;
                end
                if (rel_sync_q && osc_running && flash_init_done && fixed_done) begin
                    core_reset_d  = 1'b0;
                    core_run_d    = 1'b1;
                    flash_ready_d = 1'b1;
                    state_d       = ST_RUN;
                end
            end
            ST_RUN: begin
                vector_map_d = map_decode(map_sel);
                if (sleep_req || powerdown_req) begin
                    core_run_d = 1'b0;
                    pd_d       = powerdown_req;
                    irc_d      = clk_src_is_irc;
                    // sleep keeps flash powered, power-down does not
                    if (powerdown_req) begin
                        flash_ready_d = 1'b0;
                    end
                    state_d    = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_evt) begin
                    wake_cnt_d  = 32'h0;
                    flash_cnt_d = 32'h0;
                    state_d     = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (!core_run) begin
                    wake_cnt_d = wake_cnt_q + 32'd1;
                    if (wake_done) begin
                        core_run_d = 1'b1;
                    end
                end
                // code from sram may run before flash is back
                if (pd_q && !flash_ready) begin
                    flash_cnt_d = flash_cnt_q + 32'd1;
                    if (flash_done) begin
                        flash_ready_d = 1'b1;
                    end
                end
                if (core_run && (flash_ready || !pd_q)) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RESET;
            end
        endcase
    end

    // sequencer state and its counters
    always @(posedge clk) begin
        if (chip_reset) begin
            state_q     <= ST_RESET;
            wake_cnt_q  <= 32'h0;
            flash_cnt_q <= 32'h0;
            pd_q        <= 1'b0;
            irc_q       <= 1'b1;
        end else begin
            state_q     <= state_d;
            wake_cnt_q  <= wake_cnt_d;
            flash_cnt_q <= flash_cnt_d;
            pd_q        <= pd_d;
            irc_q       <= irc_d;
        end
    end

    always @(posedge clk) begin
        if (chip_reset) begin
            core_reset <= 1'b1;
        end else begin
            core_reset <= core_reset_d;
        end
    end

    always @(posedge clk) begin
        if (chip_reset) begin
            core_run <= 1'b0;
        end else begin
            core_run <= core_run_d;
        end
    end

    always @(posedge clk) begin
        if (chip_reset) begin
            flash_ready <= 1'b0;
        end else begin
            flash_ready <= flash_ready_d;
        end
    end

    // fetch always starts at the bottom of the map
    always @(posedge clk) begin
        if (chip_reset) begin
            fetch_addr <= `RESET_VECTOR_ADDR;
        end else begin
            fetch_addr <= `RESET_VECTOR_ADDR;
        end
    end

    always @(posedge clk) begin
        if (chip_reset) begin
            vector_map <= `MAP_BOOT;
        end else begin
            vector_map <= vector_map_d;
        end
    end

    // brownout warning: request and status share one source
    always @(posedge clk) begin
        if (chip_reset) begin
            brownout_irq <= 1'b0;
        end else begin
            brownout_irq <= brownout_warn;
        end
    end

    // status is set whether or not the interrupt is enabled
    always @(posedge clk) begin
        if (chip_reset) begin
            brownout_status <= 1'b0;
        end else begin
            brownout_status <= brownout_warn;
        end
    end

    // idle pin level is low, so no false edge after reset
    always @(posedge clk) begin
        if (chip_reset) begin
            edge_prev_q <= {N_EDGE{1'b0}};
        end else begin
            edge_prev_q <= edge_irq_in;
        end
    end

    // a new edge in the clear cycle still sets the flag
    always @(posedge clk) begin
        if (chip_reset) begin
            edge_irq_flag <= {N_EDGE{1'b0}};
        end else begin
            edge_irq_flag <= edge_keep | edge_set;
        end
    end

    always @(posedge clk) begin
        if (chip_reset) begin
            level_irq_flag <= {N_LEVEL{1'b0}};
        end else begin
            level_irq_flag <= level_irq_in & level_irq_en;
        end
    end
endmodule // reset_brownout_system_control

/* sysctl_chk.sv */
// Purpose: port assertions, reset and brownout
// Assumes: one clock domain
// Notes:   low_q counts cycles with chip reset low
`timescale 1ns/1ps
module sysctl_chk #(parameter FIXED_CYC = 64) (
    input wire clk, srst, reset_pin_n, watchdog_reset, power_on_reset, brownout_trip, brownout_warn, osc_running,
    input wire flash_init_done, sleep_req, powerdown_req, chip_reset, core_reset, core_run, brownout_irq,
    input wire brownout_status,
    input wire [1:0] map_sel, vector_map,
    input wire [31:0] fetch_addr
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    reg [15:0] low_q;
    wire quiet = !chip_reset && !core_reset;
    always @(posedge clk) low_q <= chip_reset ? 16'h0 : low_q + 16'h1;
    sequence s_go; $fell(core_reset); endsequence
    sequence s_nap; core_run && sleep_req && !powerdown_req; endsequence
    a_src_or: assert property (chip_reset == (!reset_pin_n | watchdog_reset | power_on_reset | brownout_trip))
        else $error("reset sources");
    a_hold_reset: assert property (chip_reset |-> ##[0:3] core_reset) else $error("hold");
    a_rel_cond: assert property (s_go |-> $past(osc_running && flash_init_done && !chip_reset)) else $error("early");
    a_rel_wait: assert property (s_go |-> low_q >= FIXED_CYC) else $error("short wait");
    a_fetch_zero: assert property (fetch_addr == 32'h0) else $error("fetch");
    a_boot_map: assert property (core_reset |-> vector_map == 2'h0 && !core_run) else $error("reset map");
    a_map_sel: assert property (quiet && $past(quiet) && $stable(map_sel) |-> vector_map == (&map_sel ? 2'h0 : map_sel))
        else $error("map");
    a_warn_irq: assert property (quiet && $past(quiet) |-> brownout_irq == $past(brownout_warn)) else $error("irq");
    a_warn_stat: assert property (quiet && $past(quiet) |-> brownout_status == $past(brownout_warn)) else $error("stat");
    a_sleep_stop: assert property (s_nap |=> !core_run) else $error("sleep");
endmodule // sysctl_chk
bind reset_brownout_system_control sysctl_chk #(.FIXED_CYC(FIXED_CYC)) u_chk (.*);

/* supply_model.sv */
// Purpose: supply comparators, reset pin and watchdog
// Assumes: mv is the I/O supply in millivolts
// Notes:   hysteresis left out, thresholds are exact
`timescale 1ns/1ps
module supply_model (
    input int mv, input wire pin_low, wdt,
    output wire reset_pin_n, watchdog_reset, power_on_reset, brownout_warn, brownout_trip
);
    assign reset_pin_n = !pin_low;
    assign watchdog_reset = wdt;
    assign brownout_warn = mv < 2950;
    assign brownout_trip = mv < 2650 && mv >= 1000;
    assign power_on_reset = mv < 1000;
endmodule // supply_model

/* tb_reset_brownout_system_control.sv */
// Purpose: self-checking bench
// Assumes: inputs move 1 ns after the rising edge
// Notes:   short counts keep the run brief
`timescale 1ns/1ps
module tb_reset_brownout_system_control;
    localparam FIX = 8;
    logic clk = 0, srst = 1, osc_running = 1, flash_init_done = 0, clk_src_is_irc = 1, pin_low = 0, wdt = 0;
    logic sleep_req = 0, powerdown_req = 0, edge_irq_clr = 0, reset_pin_n, watchdog_reset, power_on_reset;
    logic brownout_warn, brownout_trip, chip_reset, core_reset, brownout_irq, brownout_status, core_run, flash_ready;
    logic [1:0] map_sel = 2'h0, vector_map;
    logic [49:0] edge_irq_in = 50'h0, edge_irq_en = 50'h0, edge_wake_en = 50'h0, edge_irq_flag;
    logic [3:0] level_irq_in = 4'h0, level_irq_en = 4'h1, level_wake_en = 4'h1, level_irq_flag;
    logic [31:0] fetch_addr;
    int mv = 3300, n_errors = 0, tests_run = 0, cyc = 0, i, n;
    supply_model sup (.*);
    reset_brownout_system_control #(.FIXED_CYC(FIX), .XTAL_CYC(16), .FLASH_CYC(20)) dut (.*);
    always #5 clk = ~clk;
    always @(posedge clk) if (++cyc == 3000) begin n_errors++; tally_and_finish; end
    task stp(input int k); repeat (k) @(posedge clk); #1; endtask
    task ck(input bit ok);
        tests_run++;
        if (!ok) begin n_errors++; $display("Error %0t: port mismatch", $time); end
    endtask
    task run_wait; for (n = 0; n < 99 && core_run !== 1'b1; n++) stp(1); endtask
    task t_boot;
        stp(FIX + 6);
        ck(core_reset === 1'b1);
        flash_init_done = 1;
        run_wait;
        ck(n == 1 && {core_reset, fetch_addr, vector_map} === 35'h0);
    endtask
    task t_sources;
        for (i = 0; i < 4; i++) begin
            pin_low = i == 0; wdt = i == 1; mv = i == 2 ? 500 : i == 3 ? 2600 : 3300;
            stp(3);
            ck({chip_reset, core_reset, core_run} === 3'h6);
            pin_low = 0; wdt = 0; mv = 3300;
            run_wait;
            ck(n >= FIX && core_reset === 1'b0);
        end
    endtask
    task t_warn;
        mv = 2900;
        stp(2);
        ck({brownout_irq, brownout_status, chip_reset} === 3'h6);
        mv = 3300;
    endtask
    task t_map;
        for (i = 0; i < 4; i++) begin
            map_sel = i[1:0];
            stp(2);
            ck(vector_map === (i == 3 ? 2'h0 : i[1:0]));
        end
    endtask
    task t_irq_wake;
        edge_irq_en[49] = 1; edge_irq_in[49] = 1;
        stp(3);
        ck(edge_irq_flag[49] === 1'b1);
        edge_irq_in[49] = 0; edge_irq_clr = 1;
        stp(1);
        edge_irq_clr = 0; sleep_req = 1;
        stp(1);
        sleep_req = 0;
        stp(2);
        ck({edge_irq_flag[49], core_run} === 2'h0);
        level_irq_in = 4'h1;
        run_wait;
        ck(n >= 4 && n <= 8 && level_irq_flag[0] === 1'b1);
    endtask
    task t_pd_wake;
        stp(1);
        level_irq_in = 4'h0; clk_src_is_irc = 0; edge_wake_en[0] = 1; powerdown_req = 1;
        stp(1);
        powerdown_req = 0;
        stp(1);
        ck({core_run, flash_ready} === 2'h0);
        edge_irq_in[0] = 1;
        run_wait;
        ck(n == 17 && flash_ready === 1'b0);
        stp(3);
        ck(flash_ready === 1'b0);
        stp(1);
        ck(flash_ready === 1'b1);
        edge_irq_in[0] = 0; clk_src_is_irc = 1;
    endtask
    task tally_and_finish;
        $display("checks %0d, errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        stp(2);
        srst = 0;
        t_boot; t_sources; t_warn; t_map; t_irq_wake; t_pd_wake;
        tally_and_finish;
    end
endmodule // tb_reset_brownout_system_control
